// >>> shared/opmode_pkg.sv
// Purpose: shared constants and types for the operating-mode selection block
// Assumes: Avalon-MM slave with 32-bit data, word-aligned byte addresses
// Notes:   register map, reset values and settle counts live here
package opmode_pkg;

	localparam int ADDR_W      = 4;
	localparam int DATA_W      = 32;
	localparam int AREA_COUNT  = 8;
	localparam int SYNC_STAGES = 2;

	// byte offsets of the registers
	localparam logic [ADDR_W-1:0] OFFSET_MODE_MONITOR = 4'h0;
	localparam logic [ADDR_W-1:0] OFFSET_AREA_WIDTH   = 4'h4;
	localparam logic [ADDR_W-1:0] OFFSET_MODE_STATUS  = 4'h8;

	// mode_monitor field positions
	localparam int MON_FLASH_BIT = 3;
	localparam int MON_MODE_LSB  = 0;

	// mode_status field positions
	localparam int STAT_VALID_BIT = 0;
	localparam int STAT_ROM_BIT   = 1;
	localparam int STAT_EXT_BIT   = 2;
	localparam int STAT_BUS16_BIT = 3;
	localparam int STAT_MODE_LSB  = 4;

	// reset values
	localparam logic [2:0]  RESET_MODE_LATCH = 3'h0;
	localparam logic [7:0]  RESET_AREA_WIDTH = 8'h00;
	localparam logic [DATA_W-1:0] READ_ZERO  = 32'h0000_0000;

	// mode pin patterns
	localparam logic [2:0] PINS_MODE_4 = 3'h4;
	localparam logic [2:0] PINS_MODE_5 = 3'h5;
	localparam logic [2:0] PINS_MODE_6 = 3'h6;
	localparam logic [2:0] PINS_MODE_7 = 3'h7;

	// settle count reached after reset release before the strap is taken
	localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;

	typedef enum logic [1:0] {
		INIT_SETTLE = 2'b00,
		INIT_LOAD   = 2'b01,
		INIT_RUN    = 2'b10
	} init_state_t;

	typedef struct packed {
		logic              read;
		logic              write;
		logic [ADDR_W-1:0] address;
		logic [DATA_W-1:0] writedata;
	} avalon_req_t;

	typedef struct packed {
		logic              waitrequest;
		logic [DATA_W-1:0] readdata;
	} avalon_rsp_t;

	typedef struct packed {
		logic [2:0] mode;
		logic       modeValid;
		logic       romEnable;
		logic       extendedMode;
		logic       busWidth16;
	} mode_status_t;

endpackage : opmode_pkg

// >>> verilog/pin_sync.sv
// Purpose: two-stage synchroniser for a group of pin levels
// Assumes: inputs are asynchronous to clk_sys
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_sys,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] pinSync
);

	logic [WIDTH-1:0] stageOne;
	logic [WIDTH-1:0] next_stageOne;
	logic [WIDTH-1:0] next_pinSync;

	always_comb begin
		next_stageOne = reset ? '0 : pinIn;
		next_pinSync  = reset ? '0 : stageOne;
	end

	always_ff @(posedge clk_sys) begin
		stageOne <= next_stageOne;
		pinSync  <= next_pinSync;
	end

endmodule : pin_sync

// >>> verilog/operating_mode_select.sv
// Purpose: decode strapped mode pins, drive memory/bus mode, expose mode monitor
// Assumes: clk_sys 100 MHz, reset synchronous active high is the power-on reset
// Notes:   Avalon-MM slave, one wait cycle per access
//
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module operating_mode_select #(
	parameter int AREAS = opmode_pkg::AREA_COUNT
) (
	input  wire logic                   clk_sys,
	input  wire logic                   reset,
	input  wire logic                   manualReset,
	input  wire logic                   mode_pin_2,
	input  wire logic                   mode_pin_1,
	input  wire logic                   mode_pin_0,
	input  wire logic                   flash_write_enable_level,
	input  wire opmode_pkg::avalon_req_t busReq,
	output opmode_pkg::avalon_rsp_t     busRsp,
	output opmode_pkg::mode_status_t    modeStatus
);

	import opmode_pkg::*;

	// decoded view of a pin pattern
	function automatic logic isValidMode(input logic [2:0] pins);
		isValidMode = pins[2];
	endfunction : isValidMode

	function automatic logic romOn(input logic [2:0] pins);
		romOn = isValidMode(pins) && pins[1];
	endfunction : romOn

	function automatic logic extendedOn(input logic [2:0] pins);
		extendedOn = isValidMode(pins) && (pins != PINS_MODE_7);
	endfunction : extendedOn

	// synchronised pins
	logic [3:0] pinsRaw;
	logic [3:0] pinsSync;
	logic       manualSync;
	logic [2:0] modePinsNow;
	logic       flashNow;

	assign pinsRaw     = {flash_write_enable_level, mode_pin_2, mode_pin_1, mode_pin_0};
	assign modePinsNow = pinsSync[2:0];
	assign flashNow    = pinsSync[3];

	pin_sync #(
		.WIDTH(4)
	) u_pins (
		.clk_sys(clk_sys),
		.reset  (reset),
		.pinIn  (pinsRaw),
		.pinSync(pinsSync)
	);

	pin_sync #(
		.WIDTH(1)
	) u_manual (
		.clk_sys(clk_sys),
		.reset  (reset),
		.pinIn  (manualReset),
		.pinSync(manualSync)
	);

	// strap capture state
	init_state_t       initState;
	init_state_t       next_initState;
	logic [1:0]        settleCount;
	logic [1:0]        next_settleCount;
	logic [2:0]        strapMode;
	logic [2:0]        next_strapMode;

	// per-area access width, one flop per area
	logic [AREAS-1:0]  areaWidth;
	logic [AREAS-1:0]  next_areaWidth;
	logic              areaInit;
	logic              areaWrite;

	// bus slave state
	logic              waitReq;
	logic              next_waitReq;
	logic [DATA_W-1:0] readData;
	logic [DATA_W-1:0] next_readData;

	// monitor latch and decoded outputs
	logic [2:0]        modeLatch;
	logic [2:0]        next_modeLatch;
	mode_status_t      statusReg;
	mode_status_t      next_statusReg;

	// request qualifiers
	logic              requestNow;
	logic              accessNow;
	logic              readNow;
	logic              commitNow;
	logic              writeNow;

	// take on a high waitrequest, commit on the low one
	assign requestNow = busReq.read || busReq.write;
	assign accessNow  = requestNow && waitReq;
	assign readNow    = accessNow && busReq.read;
	assign commitNow  = requestNow && !waitReq;
	assign writeNow   = commitNow && busReq.write;

	// register word builders
	function automatic logic [DATA_W-1:0] monitorWord(
		input logic       flash,
		input logic [2:0] pins
	);
		monitorWord                    = READ_ZERO;
		monitorWord[MON_FLASH_BIT]     = flash;
		monitorWord[MON_MODE_LSB +: 3] = pins;
	endfunction : monitorWord

	function automatic logic [DATA_W-1:0] areaWord(
		input logic [AREAS-1:0] widths
	);
		areaWord            = READ_ZERO;
		areaWord[AREAS-1:0] = widths;
	endfunction : areaWord

	function automatic logic [DATA_W-1:0] statusWord(
		input mode_status_t s
	);
		statusWord                     = READ_ZERO;
		statusWord[STAT_VALID_BIT]     = s.modeValid;
		statusWord[STAT_ROM_BIT]       = s.romEnable;
		statusWord[STAT_EXT_BIT]       = s.extendedMode;
		statusWord[STAT_BUS16_BIT]     = s.busWidth16;
		statusWord[STAT_MODE_LSB +: 3] = s.mode;
	endfunction : statusWord

	// strap capture after reset and after a manual reset
	always_comb begin
		next_initState   = initState;
		next_settleCount = settleCount;
		next_strapMode   = strapMode;
		if (reset) begin
			next_initState   = INIT_SETTLE;
			next_settleCount = '0;
			next_strapMode   = RESET_MODE_LATCH;
		end else begin
			unique case (initState)
				INIT_SETTLE: begin
					next_settleCount = settleCount + 2'h1;
					if (settleCount == STRAP_SETTLE_CYCLES) begin
						next_initState = INIT_LOAD;
					end
				end
				INIT_LOAD: begin
					// pins held constant, so one sample is the mode
					next_strapMode = modePinsNow;
					next_initState = INIT_RUN;
				end
				INIT_RUN: begin
					if (manualSync) begin
						next_initState = INIT_LOAD;
					end
				end
				default: begin
					next_initState = INIT_SETTLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		initState   <= next_initState;
		settleCount <= next_settleCount;
		strapMode   <= next_strapMode;
	end

	// area write lands on the edge that answers it
	assign areaInit  = (initState == INIT_LOAD);
	assign areaWrite = writeNow && (initState == INIT_RUN) && !manualSync
		&& (busReq.address == OFFSET_AREA_WIDTH);

	for (genvar g = 0; g < AREAS; g++) begin : g_area
		logic bitNext;

		always_comb begin
			bitNext = areaWidth[g];
			if (reset) begin
				bitNext = RESET_AREA_WIDTH[g];
			end else if (areaInit) begin
				// all areas 16-bit in mode 4, else 8-bit
				bitNext = (modePinsNow == PINS_MODE_4);
			end else if (areaWrite) begin
				bitNext = busReq.writedata[g];
			end
			next_areaWidth[g] = bitNext;
		end

		always_ff @(posedge clk_sys) begin
			areaWidth[g] <= next_areaWidth[g];
		end
	end : g_area

	// one wait cycle, then a single low cycle answers
	always_comb begin
		next_waitReq = 1'b1;
		if (!reset && accessNow) begin
			next_waitReq = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		waitReq <= next_waitReq;
	end

	// read data, built on the taken edge, held until the next read
	always_comb begin
		next_readData = readData;
		if (reset) begin
			next_readData = READ_ZERO;
		end else if (readNow) begin
			unique case (busReq.address)
				OFFSET_MODE_MONITOR: begin
					next_readData = monitorWord(flashNow, modePinsNow);
				end
				OFFSET_AREA_WIDTH: begin
					next_readData = areaWord(areaWidth);
				end
				OFFSET_MODE_STATUS: begin
					next_readData = statusWord(statusReg);
				end
				default: begin
					next_readData = READ_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		readData <= next_readData;
	end

	// monitor latch, cleared only by power-on reset
	// writes to the monitor are ignored
	always_comb begin
		next_modeLatch = modeLatch;
		if (reset) begin
			next_modeLatch = RESET_MODE_LATCH;
		end else if (readNow && busReq.address == OFFSET_MODE_MONITOR) begin
			next_modeLatch = modePinsNow;
		end
	end

	always_ff @(posedge clk_sys) begin
		modeLatch <= next_modeLatch;
	end

	// decoded outputs once the strap is taken
	always_comb begin
		next_statusReg = '0;
		if (!reset && initState == INIT_RUN) begin
			next_statusReg.mode         = isValidMode(strapMode) ? strapMode : 3'h0;
			next_statusReg.modeValid    = isValidMode(strapMode);
			next_statusReg.romEnable    = romOn(strapMode);
			next_statusReg.extendedMode = extendedOn(strapMode);
			// any 16-bit area widens the bus, mode 7 and invalid patterns have none
			next_statusReg.busWidth16   = extendedOn(strapMode) && (|areaWidth);
		end
	end

	always_ff @(posedge clk_sys) begin
		statusReg <= next_statusReg;
	end

	// outputs straight from flops
	assign busRsp.waitrequest = waitReq;
	assign busRsp.readdata    = readData;
	assign modeStatus         = statusReg;

endmodule : operating_mode_select

// >>> bench/opmode_checker.sv
// Purpose: port assertions for the mode select block
// Assumes: one clock, synchronous reset
// Notes: bound to every instance
`timescale 1ns/1ps
module opmode_checker
	import opmode_pkg::*;
#(
	parameter int AREAS = 8
) (
	input wire logic         clk_sys,
	input wire logic         reset,
	input wire logic         mode_pin_2,
	input wire logic         mode_pin_1,
	input wire logic         mode_pin_0,
	input wire logic         flash_write_enable_level,
	input wire avalon_req_t  busReq,
	input wire avalon_rsp_t  busRsp,
	input wire mode_status_t modeStatus
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	sequence s_take;
		(busReq.read || busReq.write) && busRsp.waitrequest;
	endsequence
	sequence s_ack;
		!busRsp.waitrequest;
	endsequence
	a_ack_after_take: assert property (s_take |=> s_ack) else $error("request not answered");
	a_ack_single: assert property (s_ack |=> busRsp.waitrequest) else $error("answer too long");
	a_ack_cause: assert property (s_ack |-> $past(busReq.read || busReq.write)) else $error("answer without request");
	a_monitor_pins: assert property (s_ack ##0 ($past(busReq.read) && $past(busReq.address) == OFFSET_MODE_MONITOR)
		|-> busRsp.readdata[3:0] == {flash_write_enable_level, mode_pin_2, mode_pin_1, mode_pin_0})
		else $error("monitor value wrong");
	a_mode_pins: assert property (modeStatus.modeValid |-> modeStatus.mode == {mode_pin_2, mode_pin_1, mode_pin_0}
		&& mode_pin_2) else $error("mode not from pins");
	a_rom_map: assert property (modeStatus.modeValid |-> modeStatus.romEnable == modeStatus.mode[1])
		else $error("rom enable wrong");
	a_ext_map: assert property (modeStatus.modeValid |-> modeStatus.extendedMode == (modeStatus.mode != 3'h7))
		else $error("extended flag wrong");
	a_width_ext: assert property (modeStatus.busWidth16 |-> modeStatus.extendedMode)
		else $error("width outside extended");
	a_no_mode: assert property (!modeStatus.modeValid |-> !modeStatus.romEnable && !modeStatus.extendedMode
		&& !modeStatus.busWidth16 && modeStatus.mode == 3'h0) else $error("invalid mode active");
endmodule : opmode_checker

bind operating_mode_select opmode_checker #(.AREAS(AREAS)) chk (.clk_sys(clk_sys), .reset(reset),
	.mode_pin_2(mode_pin_2), .mode_pin_1(mode_pin_1), .mode_pin_0(mode_pin_0),
	.flash_write_enable_level(flash_write_enable_level), .busReq(busReq), .busRsp(busRsp),
	.modeStatus(modeStatus));

// >>> bench/tb.sv
// Purpose: register level test of the mode select block
// Assumes: answer within a few cycles
// Notes: every pin pattern with upper pin high, plus one low
`timescale 1ns/1ps
module tb;
	import opmode_pkg::*;
	logic         clk_sys, reset, manualReset, flashLvl;
	logic [2:0]   pins;
	logic [31:0]  q;
	avalon_req_t  busReq;
	avalon_rsp_t  busRsp;
	mode_status_t modeStatus;
	int           errors, compares;
	operating_mode_select dut (.clk_sys(clk_sys), .reset(reset), .manualReset(manualReset),
		.mode_pin_2(pins[2]), .mode_pin_1(pins[1]), .mode_pin_0(pins[0]), .flash_write_enable_level(flashLvl),
		.busReq(busReq), .busRsp(busRsp), .modeStatus(modeStatus));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task stop_test;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		busReq <= '{read: !w, write: w, address: a, writedata: d};
		do begin
			@(posedge clk_sys);
			n++;
		end while (busRsp.waitrequest !== 1'b0 && n < 50);
		q = busRsp.readdata;
		if (n >= 50) begin
			errors++;
			stop_test();
		end
		busReq <= '0;
		@(posedge clk_sys);
	endtask : acc
	task rd(input logic [3:0] a, input string n, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk(n, e, q);
	endtask : rd
	function automatic logic [31:0] stat(input logic [2:0] p, input logic w);
		logic v;
		v = p[2];
		return {25'h0, v ? p : 3'h0, v & w & (p != 3'h7), v & (p != 3'h7), v & p[1], v};
	endfunction : stat
	task boot(input logic [2:0] p, input logic f);
		@(posedge clk_sys);
		reset <= 1'b1;
		pins <= p;
		flashLvl <= f;
		repeat (12) @(posedge clk_sys);
		reset <= 1'b0;
		repeat (10) @(posedge clk_sys);
	endtask : boot
	initial begin
		reset = 1'b1;
		manualReset = 1'b0;
		pins = 3'h4;
		flashLvl = 1'b0;
		busReq = '0;
		errors = 0;
		compares = 0;
		for (int i = 3; i < 8; i++) begin
			boot(i[2:0], i[0]);
			rd(OFFSET_MODE_STATUS, "status", stat(i[2:0], i == 4));
			rd(OFFSET_MODE_MONITOR, "monitor", {28'h0, i[0], i[2:0]});
			acc(1'b1, OFFSET_MODE_MONITOR, 32'hffff_ffff);
			rd(OFFSET_MODE_MONITOR, "monitor kept", {28'h0, i[0], i[2:0]});
			acc(1'b1, OFFSET_AREA_WIDTH, 32'h80);
			rd(OFFSET_MODE_STATUS, "one area wide", stat(i[2:0], 1'b1));
			acc(1'b1, OFFSET_AREA_WIDTH, 32'h0);
			rd(OFFSET_MODE_STATUS, "all areas narrow", stat(i[2:0], 1'b0));
			rd(4'hc, "unmapped", 32'h0);
			$display("test pins %0d done", i);
		end
		boot(3'h4, 1'b1);
		acc(1'b1, OFFSET_AREA_WIDTH, 32'h0);
		manualReset <= 1'b1;
		repeat (4) @(posedge clk_sys);
		manualReset <= 1'b0;
		repeat (10) @(posedge clk_sys);
		rd(OFFSET_MODE_STATUS, "after manual", stat(3'h4, 1'b1));
		rd(OFFSET_MODE_MONITOR, "monitor manual", 32'h0000_000c);
		$display("test manual reset done");
		stop_test();
	end
	initial begin
		repeat (5000) @(posedge clk_sys);
		errors++;
		stop_test();
	end
endmodule : tb
